// *** verilog/asr_ctrl_defs.vh ***
// Overview of operation
// - write strobe stays high whenever the address lines change
// - array is written only while select and write strobe are both low
// - write data meets setup and hold around the terminating strobe edge
// - address stays stable at least 0 ns after write strobe rises
// - controller never drives data lines while the device drives them
// - select to end of write lasts at least 70 ns
// - read cycle at least 70 ns; device data valid within 70 ns
// - write cycle at least 70 ns; address valid 70 ns before write end
// - write strobe low at least 40 ns; data valid 40 ns before end
// - address setup 0 ns before strobe falls; data hold 0 ns after end
// - read by select: address valid at select fall, write strobe high
`ifndef ASR_CTRL_DEFS_VH
`define ASR_CTRL_DEFS_VH

`define ASR_ADDR_W 15
`define ASR_DATA_W 8
`define ASR_CLK_PS 5000
// times in ns
`define ASR_READ_CYCLE_NS 70
`define ASR_ADDR_ACCESS_NS 70
`define ASR_OUT_EN_ACCESS_NS 35
`define ASR_DESELECT_FLOAT_NS 35
`define ASR_OUT_DIS_FLOAT_NS 30
`define ASR_WRITE_CYCLE_NS 70
`define ASR_SELECT_WR_END_NS 70
`define ASR_WRITE_PULSE_NS 40
`define ASR_DATA_OVERLAP_NS 40
`define ASR_WRITE_FLOAT_NS 30
// least times round up to whole cycles, at least one
`define ASR_CYC(ns) ((((ns) * 1000 + `ASR_CLK_PS - 1) / `ASR_CLK_PS) < 1 ? 1 : \
	(((ns) * 1000 + `ASR_CLK_PS - 1) / `ASR_CLK_PS))
`define ASR_CNT_W 5
// two-flop synchroniser on the data lines
`define ASR_SYNC_STAGES 2
`define ASR_CNT_ZERO 5'h00
`define ASR_CNT_ONE 5'h01
// states
`define ASR_ST_IDLE 3'h0
`define ASR_ST_RD 3'h1
`define ASR_ST_RD_FLOAT 3'h2
`define ASR_ST_WR_SETUP 3'h3
`define ASR_ST_WR 3'h4
`define ASR_ST_WR_END 3'h5

`endif

// *** verilog/asr_sync.v ***
`timescale 1ns/1ps
`default_nettype none
`include "asr_ctrl_defs.vh"
module asr_sync (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// raw and synchronised bus
	input wire [`ASR_DATA_W-1:0] rawIn,
	output reg [`ASR_DATA_W-1:0] syncOut
);
	reg [`ASR_DATA_W-1:0] meta_q;
	genvar i;
	generate
		for (i = 0; i < `ASR_DATA_W; i = i + 1) begin : gBit
			// first stage feeds only the second stage
			always @(posedge clk) begin
				if (!rst_b) begin
					meta_q[i] <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					meta_q[i] <= rawIn[i];
					syncOut[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** verilog/asr_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "asr_ctrl_defs.vh"
module asr_ctrl (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// user request
	input wire reqValid,
	input wire reqWrite,
	input wire [`ASR_ADDR_W-1:0] reqAddr,
	input wire [`ASR_DATA_W-1:0] reqWdata,
	output reg reqReady,
	// user read answer
	output reg rspValid,
	output reg [`ASR_DATA_W-1:0] rspRdata,
	// sram pins
	output reg [`ASR_ADDR_W-1:0] addrLines,
	output reg chipSel_b,
	output reg writeStrobe_b,
	output reg outDrive_b,
	input wire [`ASR_DATA_W-1:0] dataLinesIn,
	output reg [`ASR_DATA_W-1:0] dataLinesOut,
	output reg dataLinesOe
);
	// cycle counts from printed times
	// access plus the two sync stages before sampling
	localparam integer RD_SAMPLE_I = `ASR_CYC(`ASR_ADDR_ACCESS_NS) + `ASR_SYNC_STAGES;
	localparam integer FLOAT_I = `ASR_CYC(`ASR_DESELECT_FLOAT_NS);
	localparam integer WR_I = `ASR_CYC(`ASR_SELECT_WR_END_NS);
	localparam [`ASR_CNT_W-1:0] RD_SAMPLE = RD_SAMPLE_I[`ASR_CNT_W-1:0];
	localparam [`ASR_CNT_W-1:0] FLOAT_CYC = FLOAT_I[`ASR_CNT_W-1:0];
	localparam [`ASR_CNT_W-1:0] WR_CYC = WR_I[`ASR_CNT_W-1:0];

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [`ASR_CNT_W-1:0] cnt_q;
	reg [`ASR_CNT_W-1:0] cnt_d;
	wire [`ASR_DATA_W-1:0] dataSync;

	asr_sync uSync (
		.clk(clk),
		.rst_b(rst_b),
		.rawIn(dataLinesIn),
		.syncOut(dataSync)
	);

	// next state
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q + `ASR_CNT_ONE;
		case (state_q)
		`ASR_ST_IDLE: begin
			cnt_d = `ASR_CNT_ZERO;
			if (reqValid) begin
				if (reqWrite) begin
					state_d = `ASR_ST_WR_SETUP;
				end else begin
					state_d = `ASR_ST_RD;
				end
			end
		end
		`ASR_ST_RD: begin
			// held past read cycle and access plus sync delay
			if (cnt_q == RD_SAMPLE) begin
				state_d = `ASR_ST_RD_FLOAT;
				cnt_d = `ASR_CNT_ZERO;
			end
		end
		`ASR_ST_RD_FLOAT: begin
			// wait for device release before anyone drives again
			if (cnt_q == FLOAT_CYC) begin
				state_d = `ASR_ST_IDLE;
			end
		end
		`ASR_ST_WR_SETUP: begin
			state_d = `ASR_ST_WR;
			cnt_d = `ASR_CNT_ONE;
		end
		`ASR_ST_WR: begin
			// select and strobe low together for full 70 ns
			if (cnt_q == WR_CYC) begin
				state_d = `ASR_ST_WR_END;
				cnt_d = `ASR_CNT_ZERO;
			end
		end
		`ASR_ST_WR_END: begin
			// setup, pulse and end together cover the write cycle
			state_d = `ASR_ST_IDLE;
		end
		default: begin
			state_d = `ASR_ST_IDLE;
			cnt_d = `ASR_CNT_ZERO;
		end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_b) begin
			state_q <= `ASR_ST_IDLE;
			cnt_q <= `ASR_CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// pin and user outputs, all registered
	always @(posedge clk) begin
		if (!rst_b) begin
			addrLines <= {`ASR_ADDR_W{1'b0}};
			chipSel_b <= 1'b1;
			writeStrobe_b <= 1'b1;
			outDrive_b <= 1'b1;
			dataLinesOut <= {`ASR_DATA_W{1'b0}};
			dataLinesOe <= 1'b0;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspRdata <= {`ASR_DATA_W{1'b0}};
		end else begin
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			case (state_d)
			`ASR_ST_IDLE: begin
				// standby: deselected, bus released
				chipSel_b <= 1'b1;
				writeStrobe_b <= 1'b1;
				outDrive_b <= 1'b1;
				dataLinesOe <= 1'b0;
			end
			`ASR_ST_RD: begin
				if (state_q == `ASR_ST_IDLE) begin
					// address and select change together, strobe high
					addrLines <= reqAddr;
					reqReady <= 1'b1;
				end
				writeStrobe_b <= 1'b1;
				chipSel_b <= 1'b0;
				// our drivers already off when drive goes low
				dataLinesOe <= 1'b0;
				outDrive_b <= 1'b0;
			end
			`ASR_ST_RD_FLOAT: begin
				if (state_q == `ASR_ST_RD) begin
					rspValid <= 1'b1;
					rspRdata <= dataSync;
				end
				chipSel_b <= 1'b1;
				outDrive_b <= 1'b1;
				dataLinesOe <= 1'b0;
			end
			`ASR_ST_WR_SETUP: begin
				// address settles with strobe high; drive kept off
				addrLines <= reqAddr;
				dataLinesOut <= reqWdata;
				reqReady <= 1'b1;
				writeStrobe_b <= 1'b1;
				outDrive_b <= 1'b1;
				chipSel_b <= 1'b1;
			end
			`ASR_ST_WR: begin
				// select and strobe fall together so device stays floating
				chipSel_b <= 1'b0;
				writeStrobe_b <= 1'b0;
				dataLinesOe <= 1'b1;
			end
			`ASR_ST_WR_END: begin
				// both rise together; address and data held this cycle
				chipSel_b <= 1'b1;
				writeStrobe_b <= 1'b1;
				dataLinesOe <= 1'b1;
			end
			default: begin
				chipSel_b <= 1'b1;
				writeStrobe_b <= 1'b1;
				outDrive_b <= 1'b1;
				dataLinesOe <= 1'b0;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// *** bench/asr_sram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model (
	// device pins
	input wire logic [14:0] addrLines,
	input wire logic chipSel_b,
	input wire logic writeStrobe_b,
	input wire logic outDrive_b,
	// controller drive and resolved wire
	input wire logic [7:0] ctrlData,
	input wire logic ctrlOe,
	output wire logic [7:0] dataLines
);
	logic [7:0] mem [0:32767];
	logic drv = 1'b0;
	logic [7:0] last = 8'h00;
	wire wrAct = !chipSel_b && !writeStrobe_b;
	wire rdEn = !chipSel_b && !outDrive_b && writeStrobe_b;
	always @(negedge wrAct) mem[addrLines] = dataLines;
	// slow turn-on punishes early sampling
	always @(posedge rdEn) #10 drv = rdEn;
	always @(negedge rdEn) drv = 1'b0;
	// no pull on the wire: released lines show the inverse
	always @(negedge drv) last = ~mem[addrLines];
	assign dataLines = ctrlOe ? ctrlData : drv ? mem[addrLines] : last;
endmodule
`default_nettype wire

// *** bench/asr_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_sva (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// user side
	input wire reqWrite,
	input wire reqReady,
	input wire rspValid,
	// sram pins
	input wire [14:0] addrLines,
	input wire chipSel_b,
	input wire writeStrobe_b,
	input wire outDrive_b,
	input wire [7:0] dataLinesOut,
	input wire dataLinesOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [4:0] selLow_q;
	always @(posedge clk) selLow_q <= chipSel_b ? 5'h00 : selLow_q + {4'h0, selLow_q != 5'h1f};
	addr_hold_a: assert property ($changed(addrLines) |-> writeStrobe_b && $past(writeStrobe_b))
		else $error("address moved in write");
	wr_pulse_a: assert property ($fell(writeStrobe_b) |-> !writeStrobe_b [*8])
		else $error("write pulse short");
	sel_len_a: assert property ($rose(chipSel_b) |-> selLow_q >= 5'h0e)
		else $error("select pulse short");
	data_lead_a: assert property ($rose(writeStrobe_b) |-> dataLinesOe && $past(dataLinesOe, 8) && $stable(dataLinesOut))
		else $error("write data not held");
	no_clash_a: assert property (dataLinesOe |-> outDrive_b && $past(outDrive_b))
		else $error("data drive clash");
	rd_strobe_a: assert property (!outDrive_b |-> writeStrobe_b && !chipSel_b)
		else $error("read strobes wrong");
	wr_sel_a: assert property (!writeStrobe_b |-> !chipSel_b && outDrive_b)
		else $error("write without select");
	rd_answer_a: assert property (reqReady && !reqWrite |-> ##17 rspValid)
		else $error("read answer late");
	cover property ($rose(writeStrobe_b));
	cover property (rspValid);
	cover property ($fell(outDrive_b));
endmodule
bind asr_ctrl asr_ctrl_sva u_asr_ctrl_sva (.*);
`default_nettype wire

// *** bench/async_sram_rw_timing_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module async_sram_rw_timing_tb_top;
	logic clk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
	logic [14:0] reqAddr = 15'h0000, addrLines;
	logic [7:0] reqWdata = 8'h00, rspRdata, dataLinesOut, dataLines;
	logic reqReady, rspValid, dataLinesOe, chipSel_b, writeStrobe_b, outDrive_b;
	logic [7:0] shadow [0:32767];
	logic [14:0] addrs [0:23];
	integer err_count = 0, total_checks = 0, seed = 44, i;
	always #2.5 clk = ~clk;
	asr_ctrl u_asr_ctrl (.clk, .rst_b, .reqValid, .reqWrite, .reqAddr, .reqWdata, .reqReady,
		.rspValid, .rspRdata, .addrLines, .chipSel_b, .writeStrobe_b, .outDrive_b,
		.dataLinesIn(dataLines), .dataLinesOut, .dataLinesOe);
	asr_sram_model u_asr_sram_model (.addrLines, .chipSel_b, .writeStrobe_b, .outDrive_b,
		.ctrlData(dataLinesOut), .ctrlOe(dataLinesOe), .dataLines);
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bounded wait, sampled before the edge's own updates
	// selRsp picks the read answer, otherwise the request ready
	task automatic waitHigh(input logic selRsp);
		integer n;
		logic sig;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			sig = selRsp ? rspValid : reqReady;
		end while (sig !== 1'b1 && n < 40);
		chk8({7'h00, sig}, 8'h01);
	endtask
	task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
		@(posedge clk);
		reqValid <= 1'b1;
		reqWrite <= wr;
		reqAddr <= a;
		reqWdata <= d;
		waitHigh(1'b0);
		reqValid <= 1'b0;
		if (wr) begin
			shadow[a] = d;
		end else begin
			waitHigh(1'b1);
			chk8(rspRdata, shadow[a]);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk8({5'h00, chipSel_b, writeStrobe_b, outDrive_b}, 8'h07);
		chk8({7'h00, dataLinesOe}, 8'h00);
		// edge addresses and data, overwrite, then back-to-back reads
		access(1'b1, 15'h0000, 8'hff);
		access(1'b1, 15'h7fff, 8'h00);
		access(1'b1, 15'h0000, 8'h5a);
		access(1'b0, 15'h0000, 8'h00);
		access(1'b0, 15'h7fff, 8'h00);
		$display("test corners done");
		for (i = 0; i < 24; i++) begin
			addrs[i] = 15'($random(seed));
			access(1'b1, addrs[i], 8'($random(seed)));
		end
		for (i = 0; i < 24; i++) begin
			access(1'b0, addrs[23 - i], 8'h00);
		end
		$display("test random done");
		conclude;
	end
	initial begin
		#20000;
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		conclude;
	end
endmodule
`default_nettype wire
